// ### logic/fdc_err_defs.svh
// Constants of the floppy controller error and reporting block.
// Assumes a 20 MHz pclk and byte-aligned APB word offsets.
//
// What this block does
// - Track mismatch aborts sector read/write (not FFR/FFW), sets rw end
// - Transfer fault flagged, no abort, no interrupt
// - CRC fault flags, aborts, sets end and summary
// - No data mark within 32 bytes aborts
// - Wrong sector aborts; head stays; clears when idle
// - Eighty-two steps without track zero: seek error
// - File inoperable aborts, drops head, read pulses clear
// - Write gate on protected disk aborts, drops head
// - Ready lost while busy: hard error, drop head
// - Reset clears flags except file inoperable, ready
// - Head unloads when settle time passes after rw end without command, unless a wrong sector ended it
// - Error summary is OR of error flags, bit 3
`ifndef FDC_ERR_DEFS_SVH
`define FDC_ERR_DEFS_SVH

`define OFS_CMD 8'h00
`define OFS_TARGET 8'h04
`define OFS_SETTLE 8'h08
`define OFS_MASK 8'h0C
`define OFS_DRIVE_ST 8'h10
`define OFS_ERROR_ST 8'h14
`define OFS_INT_ST 8'h18

`define CMD_STZ 4'h2
`define CMD_SEK 4'h3
`define CMD_SSR 4'h4
`define CMD_SSW 4'h5
`define CMD_RCR 4'h6
`define CMD_SWD 4'h7
`define CMD_FFR 4'hA
`define CMD_FFW 4'hB
`define CMD_MSR 4'hC
`define CMD_MSW 4'hD

`define ERR_XFER 0
`define ERR_CRC 1
`define ERR_MARK 2
`define ERR_SECTOR 3
`define ERR_SEEK 4
`define ERR_FI 5
`define ERR_WRITE 6
`define ERR_HARD 7
`define ISR_SUMMARY 3

`define MARK_WINDOW_BYTES 6'h20
`define STZ_MAX_STEPS 7'h52
`define SETTLE_UNIT_NS 1000000
`define PCLK_PERIOD_NS 50

`endif

// ### logic/fdc_err_pkg.sv
// Types shared by the floppy controller error block.
// Assumes the command engine runs on the same pclk.
package fdc_err_pkg;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } run_state_t;

  // One-cycle events from the command engine
  typedef struct packed {
    logic byte_tick;
    logic id_found;
    logic [4:0] id_sector;
    logic id_crc_bad;
    logic data_crc_bad;
    logic mark_found;
    logic xfer_fault;
    logic track_ne;
    logic step_pulse;
    logic wgate_req;
    logic cmd_done;
  } engine_ev_t;

endpackage : fdc_err_pkg

// ### logic/pin_sync.sv
// Two-flop synchroniser for drive pins.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      dout <= '0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : pin_sync

// ### logic/fdc_error_handling.sv
// Error detection and reporting of the floppy controller, APB slave.
// Assumes a command engine on pclk feeding engine_ev, drive pins async.
`timescale 1ns/10ps
`include "fdc_err_defs.svh"
module fdc_error_handling #(
  parameter int SETTLE_UNIT_CYC = `SETTLE_UNIT_NS / `PCLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive_ready_input,
  input wire logic track_zero_input,
  input wire logic file_inoperable_input,
  input wire logic write_protect_input,
  input wire fdc_err_pkg::engine_ev_t engine_ev,
  output logic head_load_output,
  output logic write_gate_output,
  output logic fi_reset_output,
  output logic busy_output,
  output logic abort_output,
  output logic irq
);
  import fdc_err_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] pins_s;
  wire ready_s = pins_s[3];
  wire tz_s = pins_s[2];
  wire fi_s = pins_s[1];
  wire wp_s = pins_s[0];

  pin_sync #(.WIDTH(4)) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .din({drive_ready_input, track_zero_input, file_inoperable_input,
          write_protect_input}),
    .dout(pins_s)
  );

  ////////////////////////////////////////////////////////////////////
  // State
  run_state_t state_reg;
  logic [3:0] cmd_reg;
  logic [4:0] target_sector_reg;
  logic [3:0] settle_reg;
  logic [3:0] mask_reg;
  logic [7:0] error_status_reg;
  logic track_ne_reg;
  logic rw_end_flag;
  logic seek_end_flag;
  logic ready_d_reg;
  logic mark_armed_reg;
  logic [5:0] mark_cnt_reg;
  logic [6:0] step_cnt_reg;
  logic settle_run_reg;
  logic [3:0] settle_cnt_reg;
  logic [14:0] unit_cnt_reg;

  wire busy = (state_reg == ST_BUSY);

  ////////////////////////////////////////////////////////////////////
  // Command classes
  function automatic logic is_read(input logic [3:0] c);
    is_read = (c == `CMD_SSR) || (c == `CMD_RCR) || (c == `CMD_MSR);
  endfunction : is_read

  function automatic logic is_write(input logic [3:0] c);
    is_write = (c == `CMD_SSW) || (c == `CMD_SWD) || (c == `CMD_MSW)
      || (c == `CMD_FFW);
  endfunction : is_write

  function automatic logic is_seek(input logic [3:0] c);
    is_seek = (c == `CMD_STZ) || (c == `CMD_SEK);
  endfunction : is_seek

  function automatic logic is_sector(input logic [3:0] c);
    is_sector = is_read(c) || (is_write(c) && c != `CMD_FFW);
  endfunction : is_sector

  function automatic logic is_valid(input logic [3:0] c);
    is_valid = is_read(c) || is_write(c) || is_seek(c) || c == `CMD_FFR;
  endfunction : is_valid

  wire cmd_rw = busy && !is_seek(cmd_reg);
  wire cmd_seek = busy && is_seek(cmd_reg);
  wire cmd_read = busy && is_read(cmd_reg);
  wire cmd_wr = busy && is_write(cmd_reg);
  wire cmd_sec = busy && is_sector(cmd_reg);
  wire cmd_stz = busy && cmd_reg == `CMD_STZ;

  ////////////////////////////////////////////////////////////////////
  // APB decode; zero wait state, read data captured in setup
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_cmd = paddr == `OFS_CMD;
  wire hit_tgt = paddr == `OFS_TARGET;
  wire hit_set = paddr == `OFS_SETTLE;
  wire hit_msk = paddr == `OFS_MASK;
  wire hit_drv = paddr == `OFS_DRIVE_ST;
  wire hit_err = paddr == `OFS_ERROR_ST;
  wire hit_isr = paddr == `OFS_INT_ST;
  wire hit_any = hit_cmd | hit_tgt | hit_set | hit_msk | hit_drv | hit_err | hit_isr;
  wire rd_err = rd && hit_err;
  wire rd_isr = rd && hit_isr;
  wire cmd_issue = wr && hit_cmd && !busy && is_valid(pwdata[3:0]);

  ////////////////////////////////////////////////////////////////////
  // Error detection
  wire tne_ev = cmd_sec && engine_ev.track_ne;
  wire mark_timeout = mark_armed_reg && engine_ev.byte_tick && !engine_ev.mark_found
    && mark_cnt_reg == `MARK_WINDOW_BYTES - 6'h01;
  wire sector_bad = cmd_sec && engine_ev.id_found
    && (engine_ev.id_sector != target_sector_reg || engine_ev.id_crc_bad);
  wire [7:0] err_set;
  assign err_set[`ERR_XFER] = busy && engine_ev.xfer_fault;
  assign err_set[`ERR_CRC] = cmd_rw && (engine_ev.data_crc_bad
    || engine_ev.id_crc_bad);
  assign err_set[`ERR_MARK] = cmd_read && mark_timeout;
  assign err_set[`ERR_SECTOR] = sector_bad;
  assign err_set[`ERR_SEEK] = cmd_stz && engine_ev.step_pulse && !tz_s
    && step_cnt_reg == `STZ_MAX_STEPS - 7'h01;
  assign err_set[`ERR_FI] = busy && fi_s;
  assign err_set[`ERR_WRITE] = cmd_wr && write_gate_output && wp_s;
  assign err_set[`ERR_HARD] = busy && ready_d_reg && !ready_s;

  // Transfer fault alone lets the command run on
  wire abort = tne_ev || (|err_set[7:1]);
  wire end_ev = busy && (abort || engine_ev.cmd_done);
  wire rw_end_set = end_ev && cmd_rw;
  wire seek_end_set = end_ev && cmd_seek;
  wire drop_head = err_set[`ERR_FI] || err_set[`ERR_WRITE] || err_set[`ERR_HARD]
    || (!busy && !ready_s);

  ////////////////////////////////////////////////////////////////////
  // Status views and read clear
  // Clearing only what was returned keeps a flag set between setup and access
  wire [7:0] error_view = {error_status_reg[7:6], fi_s, error_status_reg[4:0]};
  wire summary = |error_view;
  wire [3:0] isr_view = {summary, 1'b0, seek_end_flag, rw_end_flag};
  // Transfer fault shows in the summary bit but never interrupts
  wire [3:0] isr_irq = {|error_view[7:1], 1'b0, seek_end_flag, rw_end_flag};
  wire [7:0] drive_view = {busy, 1'b0, track_ne_reg, wp_s, tz_s, ready_s, 2'b00};
  wire [7:0] err_clr = rd_err ? (prdata[7:0] & {4'hF, !busy, 3'h7}) : 8'h00;
  wire [7:0] error_next = ((error_status_reg & ~err_clr) | err_set) & 8'hDF;
  wire rw_end_next = (rw_end_flag && !(rd_isr && prdata[0])) || rw_end_set;
  wire seek_end_next = (seek_end_flag && !(rd_isr && prdata[1])) || seek_end_set;
  wire [31:0] rd_mux = hit_tgt ? {27'h0, target_sector_reg}
    : hit_set ? {28'h0, settle_reg}
    : hit_msk ? {28'h0, mask_reg}
    : hit_drv ? {24'h0, drive_view}
    : hit_err ? {24'h0, error_view}
    : hit_isr ? {28'h0, isr_view} : 32'h0;

  ////////////////////////////////////////////////////////////////////
  // Head settle timer on a one-cycle unit enable
  wire unit_tick = unit_cnt_reg == 15'(SETTLE_UNIT_CYC - 1);
  wire settle_done = settle_run_reg && settle_cnt_reg == settle_reg;
  wire head_next = drop_head ? 1'b0 : cmd_issue ? 1'b1
    : settle_done ? 1'b0 : head_load_output;
  wire wgate_next = cmd_wr && engine_ev.wgate_req && !abort && !drop_head;

  ////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      prdata <= setup ? rd_mux : prdata;
      pslverr <= setup ? !hit_any : 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 4'h0;
      target_sector_reg <= 5'h00;
      settle_reg <= 4'h0;
      mask_reg <= 4'h0;
    end else begin
      if (cmd_issue) cmd_reg <= pwdata[3:0];
      if (wr && hit_tgt) target_sector_reg <= pwdata[4:0];
      if (wr && hit_set) settle_reg <= pwdata[3:0];
      if (wr && hit_msk) mask_reg <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      busy_output <= 1'b0;
      abort_output <= 1'b0;
    end else begin
      if (cmd_issue) state_reg <= ST_BUSY;
      else if (end_ev) state_reg <= ST_IDLE;
      busy_output <= cmd_issue || (busy && !end_ev);
      abort_output <= busy && abort;
    end
  end

  // Flags; file inoperable and ready are live pin views
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_status_reg <= 8'h00;
      rw_end_flag <= 1'b0;
      seek_end_flag <= 1'b0;
      track_ne_reg <= 1'b0;
      irq <= 1'b0;
      fi_reset_output <= 1'b0;
    end else begin
      error_status_reg <= error_next;
      rw_end_flag <= rw_end_next;
      seek_end_flag <= seek_end_next;
      if (cmd_issue && is_sector(pwdata[3:0])) track_ne_reg <= 1'b0;
      else if (busy && engine_ev.track_ne) track_ne_reg <= 1'b1;
      irq <= |(isr_irq & mask_reg);
      fi_reset_output <= rd_err && fi_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_d_reg <= 1'b0;
      mark_armed_reg <= 1'b0;
      mark_cnt_reg <= 6'h00;
      step_cnt_reg <= 7'h00;
    end else begin
      ready_d_reg <= ready_s;
      if (cmd_read && engine_ev.id_found && !sector_bad) begin
        mark_armed_reg <= 1'b1;
        mark_cnt_reg <= 6'h00;
      end else if (end_ev || engine_ev.mark_found || mark_timeout) begin
        mark_armed_reg <= 1'b0;
      end else if (mark_armed_reg && engine_ev.byte_tick) begin
        mark_cnt_reg <= mark_cnt_reg + 6'h01;
      end
      if (cmd_issue) step_cnt_reg <= 7'h00;
      else if (cmd_stz && engine_ev.step_pulse && step_cnt_reg != `STZ_MAX_STEPS)
        step_cnt_reg <= step_cnt_reg + 7'h01;
    end
  end

  // Sector fault keeps the head loaded past the settle time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_cnt_reg <= 15'h0000;
      settle_run_reg <= 1'b0;
      settle_cnt_reg <= 4'h0;
      head_load_output <= 1'b0;
      write_gate_output <= 1'b0;
    end else begin
      unit_cnt_reg <= unit_tick ? 15'h0000 : unit_cnt_reg + 15'h0001;
      if (rw_end_set && !sector_bad) begin
        settle_run_reg <= 1'b1;
        settle_cnt_reg <= 4'h0;
      end else if (cmd_issue || settle_done) begin
        settle_run_reg <= 1'b0;
      end else if (settle_run_reg && unit_tick) begin
        settle_cnt_reg <= settle_cnt_reg + 4'h1;
      end
      head_load_output <= head_next;
      write_gate_output <= wgate_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_ready_lost;
    busy && ready_d_reg && !ready_s;
  endsequence

  sequence s_head_down;
    !head_load_output && !write_gate_output;
  endsequence

  chk_tne_abort: assert property (@(posedge pclk) disable iff (!presetn)
    tne_ev |=> rw_end_flag && !busy_output)
    else $error("track mismatch did not abort");

  chk_xfer_continues: assert property (@(posedge pclk) disable iff (!presetn)
    err_set[`ERR_XFER] && !abort && !engine_ev.cmd_done |=> busy && error_status_reg[0])
    else $error("transfer fault stopped command or was not flagged");

  chk_crc_abort: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_rw && engine_ev.data_crc_bad |=> error_status_reg[1] && rw_end_flag && !busy)
    else $error("crc fault not reported");

  chk_mark_window: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_read && mark_timeout |=> error_status_reg[2] && rw_end_flag ##0 !mark_armed_reg)
    else $error("missing data mark not flagged");

  chk_sector_hold: assert property (@(posedge pclk) disable iff (!presetn)
    sector_bad |=> error_status_reg[3] && !settle_run_reg)
    else $error("sector fault did not hold head");

  chk_seek_steps: assert property (@(posedge pclk) disable iff (!presetn)
    err_set[`ERR_SEEK] |=> error_status_reg[4] && seek_end_flag && !busy)
    else $error("seek error not reported");

  chk_fi_drop: assert property (@(posedge pclk) disable iff (!presetn)
    busy && fi_s |=> s_head_down and !busy_output)
    else $error("file inoperable did not drop head");

  chk_wp_drop: assert property (@(posedge pclk) disable iff (!presetn)
    err_set[`ERR_WRITE] |=> error_status_reg[6] ##0 s_head_down)
    else $error("write on protected disk not stopped");

  chk_ready_lost: assert property (@(posedge pclk) disable iff (!presetn)
    s_ready_lost |=> error_status_reg[7] ##0 s_head_down ##0 !busy)
    else $error("hard error not handled");

  chk_idle_unload: assert property (@(posedge pclk) disable iff (!presetn)
    !busy && !ready_s |=> !head_load_output && !$rose(rw_end_flag) && !$rose(seek_end_flag))
    else $error("idle not ready kept head or interrupted");

  chk_settle_unload: assert property (@(posedge pclk) disable iff (!presetn)
    settle_done && !cmd_issue |=> !head_load_output)
    else $error("head kept past settle time");

  chk_summary_irq: assert property (@(posedge pclk) disable iff (!presetn)
    isr_irq[`ISR_SUMMARY] && mask_reg[`ISR_SUMMARY] |=> irq)
    else $error("error summary did not interrupt");

  chk_xfer_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
    error_view == 8'h01 && !rw_end_flag && !seek_end_flag |=> !irq)
    else $error("transfer fault raised an interrupt");

  chk_fi_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    rd_err && fi_s |=> fi_reset_output)
    else $error("file inoperable clear pulse missing");

endmodule : fdc_error_handling

// ### verif/drive_model.sv
// Behavioural floppy drive seen from the controller's pins.
// Assumes the bench steers ready, protect and fault from pclk-aligned controls.
`timescale 1ns/10ps
module drive_model (
  input wire logic pclk,
  input wire logic ready_ctl,
  input wire logic wp_ctl,
  input wire logic fi_set,
  input wire logic [7:0] tz_at,
  input wire logic step_pulse,
  input wire logic fi_reset_output,
  output logic drive_ready_input,
  output logic track_zero_input,
  output logic file_inoperable_input,
  output logic write_protect_input
);
  logic [7:0] steps_reg = 8'h00;
  logic fi_reg = 1'b0;
  ////////////////////////////////////////////////////////////////
  // No controller reset here: the drive keeps its own state
  always @(posedge pclk) begin
    if (step_pulse) steps_reg <= steps_reg + 8'h01;
    if (fi_set) fi_reg <= 1'b1;
    else if (fi_reset_output) fi_reg <= 1'b0;
  end
  // Zero target means the head never finds track zero
  assign track_zero_input = (tz_at != 8'h00) && (steps_reg >= tz_at);
  assign file_inoperable_input = fi_reg;
  assign drive_ready_input = ready_ctl;
  assign write_protect_input = wp_ctl;
endmodule : drive_model

// ### verif/tb.sv
// Self-checking bench of the error block, APB master plus engine events.
// Assumes the settle unit is shortened to 4 cycles.
`timescale 1ns/10ps
`include "fdc_err_defs.svh"
module tb;
  import fdc_err_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rdy, tz, fi, wp;
  logic ready_ctl = 1'b1;
  logic wp_ctl = 1'b0;
  logic fi_set = 1'b0;
  logic [7:0] tz_at = 8'h00;
  engine_ev_t ev = '0;
  logic head_load_output, write_gate_output, fi_reset_output, busy_output, abort_output, irq;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  always #25 pclk = ~pclk;
  fdc_error_handling #(.SETTLE_UNIT_CYC(4)) i_fdc_error_handling (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_ready_input(rdy), .track_zero_input(tz), .file_inoperable_input(fi),
    .write_protect_input(wp), .engine_ev(ev), .head_load_output(head_load_output),
    .write_gate_output(write_gate_output), .fi_reset_output(fi_reset_output),
    .busy_output(busy_output), .abort_output(abort_output), .irq(irq));
  drive_model i_drive_model (.pclk(pclk), .ready_ctl(ready_ctl), .wp_ctl(wp_ctl),
    .fi_set(fi_set), .tz_at(tz_at), .step_pulse(ev.step_pulse),
    .fi_reset_output(fi_reset_output), .drive_ready_input(rdy), .track_zero_input(tz),
    .file_inoperable_input(fi), .write_protect_input(wp));
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Leading edge keeps two requests from landing in one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x,
                     input logic [31:0] m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(n, r & m, x);
  endtask : rdc
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic fire(input engine_ev_t e);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= '0;
  endtask : fire
  task automatic start(input logic [3:0] c);
    wr(`OFS_CMD, {28'h0, c});
    tick(2);
    check("busy", busy_output, 1'b1);
  endtask : start
  task automatic finish(input logic [31:0] err, input logic [31:0] isr);
    for (int i = 0; i < 20 && busy_output !== 1'b0; i++) @(posedge pclk);
    tick(3);
    check("busy_end", busy_output, 1'b0);
    check("irq_on", irq, 1'b1);
    rdc("isr", `OFS_INT_ST, isr | ((err != 0) ? 32'h8 : 32'h0), '1);
    rdc("err", `OFS_ERROR_ST, err, '1);
    tick(6);
    rdc("err_clr", `OFS_ERROR_ST, 32'h0, '1);
    rdc("isr_clr", `OFS_INT_ST, 32'h0, '1);
  endtask : finish
  task automatic cfg;
    wr(`OFS_SETTLE, 32'h2);
    wr(`OFS_TARGET, 32'h5);
    wr(`OFS_MASK, 32'hF);
  endtask : cfg
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    engine_ev_t ev_x;
    ev_x = '0;
    ev_x.xfer_fault = 1'b1;
    rdc("err_rst", `OFS_ERROR_ST, 32'h0, '1);
    rdc("drv_rst", `OFS_DRIVE_ST, 32'h4, '1);
    apb(1'b0, 8'h1C, 32'h0, r, e);
    check("unmapped_data", r, 32'h0);
    check("unmapped_err", e, 1'b1);
    // Leave flags set so that the mid-run reset has something to clear
    start(`CMD_SSR);
    fire(ev_x);
    fi_set <= 1'b1;
    tick(1);
    fi_set <= 1'b0;
    tick(4);
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    cfg();
    check("busy_rst", busy_output, 1'b0);
    rdc("isr_rst", `OFS_INT_ST, 32'h8, '1);
    rdc("fi_kept", `OFS_ERROR_ST, 32'h20, '1);
    tick(6);
    rdc("fi_pulse", `OFS_ERROR_ST, 32'h0, '1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_crc;
    engine_ev_t e;
    logic f;
    e = '0;
    e.data_crc_bad = 1'b1;
    start(`CMD_SSR);
    fire(e);
    f = 1'b0;
    repeat (8) begin
      @(posedge pclk);
      if (abort_output === 1'b1) f = 1'b1;
    end
    check("abort", f, 1'b1);
    wr(`OFS_MASK, 32'h0);
    tick(3);
    check("irq_masked", irq, 1'b0);
    wr(`OFS_MASK, 32'hF);
    finish(32'h2, 32'h1);
    $display("test crc done");
  endtask : t_crc
  task automatic t_xfer;
    engine_ev_t e;
    e = '0;
    e.xfer_fault = 1'b1;
    start(`CMD_SSR);
    fire(e);
    tick(4);
    check("xfer_busy", busy_output, 1'b1);
    check("xfer_irq", irq, 1'b0);
    rdc("xfer_flag", `OFS_ERROR_ST, 32'h1, '1);
    rdc("xfer_clr", `OFS_ERROR_ST, 32'h0, '1);
    e = '0;
    e.cmd_done = 1'b1;
    fire(e);
    tick(3);
    check("head_settle", head_load_output, 1'b1);
    tick(12);
    check("head_unload", head_load_output, 1'b0);
    rdc("isr_end", `OFS_INT_ST, 32'h1, '1);
    $display("test xfer done");
  endtask : t_xfer
  task automatic t_mark;
    engine_ev_t e;
    e = '0;
    e.id_found = 1'b1;
    e.id_sector = 5'h05;
    start(`CMD_RCR);
    fire(e);
    e = '0;
    e.byte_tick = 1'b1;
    repeat (31) fire(e);
    tick(3);
    check("mark_31", busy_output, 1'b1);
    fire(e);
    finish(32'h4, 32'h1);
    $display("test mark done");
  endtask : t_mark
  task automatic t_seek;
    engine_ev_t e;
    e = '0;
    e.step_pulse = 1'b1;
    start(`CMD_STZ);
    repeat (81) fire(e);
    tick(3);
    check("seek_81", busy_output, 1'b1);
    fire(e);
    finish(32'h10, 32'h2);
    $display("test seek done");
  endtask : t_seek
  task automatic t_track;
    engine_ev_t e;
    e = '0;
    e.track_ne = 1'b1;
    start(`CMD_SSR);
    fire(e);
    tick(3);
    rdc("trk_set", `OFS_DRIVE_ST, 32'h20, 32'h20);
    finish(32'h0, 32'h1);
    start(`CMD_SSR);
    rdc("trk_clr", `OFS_DRIVE_ST, 32'h0, 32'h20);
    e = '0;
    e.cmd_done = 1'b1;
    fire(e);
    finish(32'h0, 32'h1);
    $display("test track done");
  endtask : t_track
  task automatic t_sector;
    engine_ev_t e;
    e = '0;
    e.id_found = 1'b1;
    e.id_sector = 5'h03;
    start(`CMD_SSR);
    fire(e);
    finish(32'h8, 32'h1);
    check("head_stays", head_load_output, 1'b1);
    ready_ctl <= 1'b0;
    tick(6);
    check("idle_head", head_load_output, 1'b0);
    check("idle_irq", irq, 1'b0);
    rdc("idle_rdy", `OFS_DRIVE_ST, 32'h0, 32'h4);
    ready_ctl <= 1'b1;
    tick(4);
    $display("test sector done");
  endtask : t_sector
  task automatic t_fi;
    start(`CMD_SSR);
    fi_set <= 1'b1;
    tick(1);
    fi_set <= 1'b0;
    tick(5);
    check("fi_head", head_load_output, 1'b0);
    check("fi_gate", write_gate_output, 1'b0);
    finish(32'h20, 32'h1);
    $display("test fi done");
  endtask : t_fi
  task automatic t_wp;
    engine_ev_t e;
    e = '0;
    e.wgate_req = 1'b1;
    start(`CMD_SSW);
    @(posedge pclk);
    ev <= e;
    tick(2);
    check("gate_on", write_gate_output, 1'b1);
    e.cmd_done = 1'b1;
    fire(e);
    finish(32'h0, 32'h1);
    e.cmd_done = 1'b0;
    wp_ctl <= 1'b1;
    tick(4);
    start(`CMD_SSW);
    fire(e);
    tick(4);
    check("wp_gate", write_gate_output, 1'b0);
    check("wp_head", head_load_output, 1'b0);
    finish(32'h40, 32'h1);
    wp_ctl <= 1'b0;
    $display("test wp done");
  endtask : t_wp
  task automatic t_hard;
    start(`CMD_SSR);
    ready_ctl <= 1'b0;
    tick(6);
    check("hard_head", head_load_output, 1'b0);
    ready_ctl <= 1'b1;
    finish(32'h80, 32'h1);
    $display("test hard done");
  endtask : t_hard
  ////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    tick(6);
    presetn <= 1'b1;
    cfg();
    t_reset();
    t_crc();
    t_xfer();
    t_mark();
    t_seek();
    t_track();
    t_sector();
    t_fi();
    t_wp();
    t_hard();
    give_verdict();
  end
endmodule : tb
